// [flash_host_pkg.sv]
package flash_host_pkg;

  // ==========================================================
  // timing, in ns as specified, and derived cycle counts
  localparam int CLK_MHZ        = 40;
  localparam int RESET_LOW_NS   = 100;
  localparam int OUT_VALID_NS   = 500;
  localparam int WRITE_READY_NS = 300;
  localparam int ACCESS_NS      = 90;
  localparam int WE_LOW_NS      = 50;
  localparam int SYNC_DEPTH     = 3;
  localparam int CNT_W          = 8;

  // least times, so round up; never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam logic [CNT_W-1:0] RESET_LOW_CYC   =
    CNT_W'(ns_to_cyc(RESET_LOW_NS));
  localparam logic [CNT_W-1:0] OUT_VALID_CYC   =
    CNT_W'(ns_to_cyc(OUT_VALID_NS));
  localparam logic [CNT_W-1:0] WRITE_READY_CYC =
    CNT_W'(ns_to_cyc(WRITE_READY_NS));
  localparam logic [CNT_W-1:0] READ_WAIT_CYC   =
    CNT_W'(ns_to_cyc(ACCESS_NS) + SYNC_DEPTH);
  localparam logic [CNT_W-1:0] WE_LOW_CYC      =
    CNT_W'(ns_to_cyc(WE_LOW_NS));
  localparam logic [CNT_W-1:0] REL_MAX_CYC     =
    (OUT_VALID_CYC > WRITE_READY_CYC) ? OUT_VALID_CYC : WRITE_READY_CYC;

  // ==========================================================
  // widths
  localparam int ADDR_W  = 19;
  localparam int DATA_W  = 16;
  localparam int UADDR_W = ADDR_W + 1;
  localparam int BYTE_W  = 8;
  localparam int HI_BIT  = DATA_W - 1;

  // ==========================================================
  // types
  typedef enum logic {
    OP_READ,
    OP_WRITE
  } op_kind_type;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_IDLE,
    ST_READ,
    ST_SAMPLE,
    ST_WRITE,
    ST_WHOLD
  } state_type;

  typedef struct packed {
    op_kind_type         kind;
    logic [UADDR_W-1:0]  addr;
    logic [DATA_W-1:0]   data;
  } host_req_type;

  typedef struct packed {
    logic               chip_sel_n;
    logic               out_en_n;
    logic               wr_strobe_n;
    logic               reset_powerdown_pin;
    logic               rp_high_voltage;
    logic               byte_wide_n;
    logic               boot_protect_n;
    logic [ADDR_W-1:0]  addr;
  } flash_pins_type;

  // strobe and selects idle high in reset: no stray write edge on release
  localparam flash_pins_type PINS_RESET = '{
    chip_sel_n:  1'b1,
    out_en_n:    1'b1,
    wr_strobe_n: 1'b1,
    byte_wide_n: 1'b1,
    default:     '0
  };

endpackage : flash_host_pkg

// [flash_host_ctrl.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - host starts program or erase only through command writes
// - after reset release, no read data trusted before output-valid time
// - after reset release, no command write before write-ready time
// - system reset drives the reset pin, returning flash to array reads
// - width select caught in every reset, power-up or warm, and held until the next reset
module flash_host_ctrl (
  // clock, reset, enable
  input  wire logic                           clk_in,
  input  wire logic                           resetn_in,
  input  wire logic                           clk_en_in,
  // system controls
  input  wire logic                           warm_reset_in,
  input  wire logic                           byte_mode_in,
  input  wire logic                           boot_unlock_in,
  input  wire logic                           hv_unlock_in,
  // user request and answer
  input  wire logic                           req_valid_in,
  input  wire flash_host_pkg::host_req_type   req_in,
  output logic                                req_ready_out,
  output logic                                rsp_valid_out,
  output logic [flash_host_pkg::DATA_W-1:0]   rsp_data_out,
  output logic                                write_ok_out,
  // flash pins
  output flash_host_pkg::flash_pins_type      pins_out,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
  output logic [flash_host_pkg::DATA_W-1:0]   dq_out,
  output logic [flash_host_pkg::DATA_W-1:0]   dq_oe_out
);

  // ==========================================================
  // state
  flash_host_pkg::state_type             state_reg, state_next;
  logic [flash_host_pkg::CNT_W-1:0]      cnt_reg, cnt_next;
  logic [flash_host_pkg::CNT_W-1:0]      rel_reg;
  flash_host_pkg::host_req_type          req_reg;
  flash_host_pkg::flash_pins_type        pins_reg, pins_next;
  logic [flash_host_pkg::DATA_W-1:0]     dq_s1_reg, dq_s2_reg, dq_s3_reg;
  logic [flash_host_pkg::DATA_W-1:0]     rsp_data_reg;
  logic                                  rsp_valid_reg;
  logic                                  wr_s1_reg, wr_s2_reg, wr_s3_reg;
  logic                                  warm_reg;
  logic                                  byte_reg;

  // ==========================================================
  // decode
  wire logic rd_ok    = rel_reg >= flash_host_pkg::OUT_VALID_CYC;
  wire logic wr_ok    = rel_reg >= flash_host_pkg::WRITE_READY_CYC;
  wire logic is_write = req_in.kind == flash_host_pkg::OP_WRITE;
  wire logic kind_ok  = is_write ? wr_ok : rd_ok;
  wire logic idle     = state_reg == flash_host_pkg::ST_IDLE;
  wire logic take     = idle && req_valid_in && kind_ok && !warm_reg;
  wire logic agree    = dq_s2_reg == dq_s3_reg;
  wire logic cnt_done = (state_reg == flash_host_pkg::ST_RESET) ?
    (cnt_reg >= flash_host_pkg::RESET_LOW_CYC) :
    (state_reg == flash_host_pkg::ST_READ) ?
    (cnt_reg >= flash_host_pkg::READ_WAIT_CYC) :
    (cnt_reg >= flash_host_pkg::WE_LOW_CYC);
  wire logic drive_st = (state_next == flash_host_pkg::ST_WRITE) ||
                        (state_next == flash_host_pkg::ST_WHOLD);
  wire logic [flash_host_pkg::DATA_W-1:0] rd_word = byte_reg ?
    {{flash_host_pkg::BYTE_W{1'b0}}, dq_s3_reg[flash_host_pkg::BYTE_W-1:0]}
    : dq_s3_reg;

  assign req_ready_out = idle && kind_ok && !warm_reg;
  assign write_ok_out  = wr_ok;
  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_data_out  = rsp_data_reg;
  assign pins_out      = pins_reg;

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 1'b1;
    case (state_reg)
      flash_host_pkg::ST_RESET: begin
        if (cnt_done && !warm_reg) begin
          state_next = flash_host_pkg::ST_IDLE;
        end
      end
      flash_host_pkg::ST_IDLE: begin
        cnt_next = '0;
        if (take) begin
          state_next = is_write ? flash_host_pkg::ST_WRITE
                                : flash_host_pkg::ST_READ;
        end
      end
      flash_host_pkg::ST_READ: begin
        if (cnt_done) begin
          state_next = flash_host_pkg::ST_SAMPLE;
        end
      end
      flash_host_pkg::ST_SAMPLE: begin
        // bus still settling when stages differ; wait a cycle
        if (agree) begin
          state_next = flash_host_pkg::ST_IDLE;
        end
      end
      flash_host_pkg::ST_WRITE: begin
        if (cnt_done) begin
          state_next = flash_host_pkg::ST_WHOLD;
        end
      end
      flash_host_pkg::ST_WHOLD: begin
        state_next = flash_host_pkg::ST_IDLE;
      end
      default: begin
        state_next = flash_host_pkg::ST_RESET;
      end
    endcase
    if (warm_reg) begin
      state_next = flash_host_pkg::ST_RESET;
      cnt_next   = '0;
    end
  end

  // ==========================================================
  // pin values follow next state, then registered
  always_comb begin
    pins_next                     = pins_reg;
    pins_next.chip_sel_n          = !(state_next inside
      {flash_host_pkg::ST_READ, flash_host_pkg::ST_SAMPLE,
       flash_host_pkg::ST_WRITE, flash_host_pkg::ST_WHOLD});
    pins_next.out_en_n            = !(state_next inside
      {flash_host_pkg::ST_READ, flash_host_pkg::ST_SAMPLE});
    // strobe only ever falls inside a command write
    pins_next.wr_strobe_n         =
      state_next != flash_host_pkg::ST_WRITE;
    pins_next.reset_powerdown_pin =
      state_next != flash_host_pkg::ST_RESET;
    pins_next.rp_high_voltage     = pins_next.reset_powerdown_pin &&
      hv_unlock_in;
    pins_next.boot_protect_n      = boot_unlock_in;
    pins_next.byte_wide_n         = !byte_reg;
    if (take) begin
      pins_next.addr = req_in.addr[flash_host_pkg::UADDR_W-1:1];
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= flash_host_pkg::ST_RESET;
      cnt_reg   <= '0;
      pins_reg  <= flash_host_pkg::PINS_RESET;
      req_reg   <= '0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pins_reg  <= pins_next;
      if (take) begin
        req_reg <= req_in;
      end
    end
  end

  // release counter gates reads and writes after reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rel_reg <= '0;
    end else if (clk_en_in) begin
      if (state_reg == flash_host_pkg::ST_RESET) begin
        rel_reg <= '0;
      end else if (rel_reg < flash_host_pkg::REL_MAX_CYC) begin
        rel_reg <= rel_reg + 1'b1;
      end
    end
  end

  // width strap caught only while the flash is held in reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      byte_reg <= 1'b0;
    end else if (clk_en_in &&
                 state_reg == flash_host_pkg::ST_RESET) begin
      byte_reg <= byte_mode_in;
    end
  end

  // pin inputs: three stages, a change counts when last two agree
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
      dq_s3_reg <= '0;
      wr_s1_reg <= 1'b1;
      wr_s2_reg <= 1'b1;
      wr_s3_reg <= 1'b1;
      warm_reg  <= 1'b1;
    end else if (clk_en_in) begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
      wr_s1_reg <= warm_reset_in;
      wr_s2_reg <= wr_s1_reg;
      wr_s3_reg <= wr_s2_reg;
      if (wr_s2_reg == wr_s3_reg) begin
        warm_reg <= wr_s3_reg;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= '0;
    end else if (clk_en_in) begin
      rsp_valid_reg <= 1'b0;
      if (state_reg == flash_host_pkg::ST_SAMPLE && agree && !warm_reg) begin
        rsp_valid_reg <= 1'b1;
        rsp_data_reg  <= rd_word;
      end
    end
  end

  // ==========================================================
  // data pins: data held through the strobe rising edge, unless a warm reset ends the write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dq_out    <= '0;
      dq_oe_out <= '0;
    end else if (clk_en_in) begin
      dq_out    <= (drive_st && !take) ? req_reg.data : req_in.data;
      dq_oe_out <= drive_st ? {flash_host_pkg::DATA_W{1'b1}} : '0;
      if (byte_reg) begin
        // upper lane floats; top pin carries the low address bit
        dq_out[flash_host_pkg::HI_BIT-1:flash_host_pkg::BYTE_W] <= '0;
        dq_oe_out[flash_host_pkg::HI_BIT-1:flash_host_pkg::BYTE_W] <= '0;
        dq_out[flash_host_pkg::HI_BIT]    <= take ? req_in.addr[0]
                                                  : req_reg.addr[0];
        dq_oe_out[flash_host_pkg::HI_BIT] <=
          state_next != flash_host_pkg::ST_RESET &&
          state_next != flash_host_pkg::ST_IDLE;
      end
    end
  end

  // ==========================================================
  // checks
  property p_wr_ready;
    @(posedge clk_in) disable iff (!resetn_in)
    !pins_out.wr_strobe_n |-> rel_reg >= flash_host_pkg::WRITE_READY_CYC;
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("early write");

  property p_rd_ready;
    @(posedge clk_in) disable iff (!resetn_in)
    rsp_valid_out |-> rel_reg >= flash_host_pkg::OUT_VALID_CYC;
  endproperty
  a_rd_ready: assert property (p_rd_ready) else $error("early read");

  property p_warm_reset;
    @(posedge clk_in) disable iff (!resetn_in)
    (warm_reg && clk_en_in) ##1 clk_en_in |=>
      !pins_out.reset_powerdown_pin;
  endproperty
  a_warm_reset: assert property (p_warm_reset)
    else $error("reset pin not low");

  property p_width_held;
    @(posedge clk_in) disable iff (!resetn_in)
    state_reg != flash_host_pkg::ST_RESET && $past(state_reg) !=
      flash_host_pkg::ST_RESET |-> $stable(pins_out.byte_wide_n);
  endproperty
  a_width_held: assert property (p_width_held)
    else $error("width changed");

  property p_strobe_hold;
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(pins_out.wr_strobe_n) |-> $stable(dq_out) && dq_oe_out[0];
  endproperty
  a_strobe_hold: assert property (p_strobe_hold)
    else $error("data moved at strobe");

  property p_strobe_clean;
    @(posedge clk_in) disable iff (!resetn_in)
    !pins_out.wr_strobe_n |-> !pins_out.chip_sel_n && pins_out.out_en_n;
  endproperty
  a_strobe_clean: assert property (p_strobe_clean)
    else $error("bad strobe");

  property p_hv_only_run;
    @(posedge clk_in) disable iff (!resetn_in)
    pins_out.rp_high_voltage |-> pins_out.reset_powerdown_pin;
  endproperty
  a_hv_only_run: assert property (p_hv_only_run)
    else $error("high voltage in reset");

  property p_byte_addr;
    @(posedge clk_in) disable iff (!resetn_in)
    byte_reg && !pins_out.out_en_n |->
      dq_oe_out[flash_host_pkg::HI_BIT] &&
      dq_out[flash_host_pkg::HI_BIT] == req_reg.addr[0];
  endproperty
  a_byte_addr: assert property (p_byte_addr)
    else $error("byte address lost");

  c_read:  cover property (@(posedge clk_in) rsp_valid_out);
  c_write: cover property (@(posedge clk_in) $rose(pins_out.wr_strobe_n));
  c_warm:  cover property (@(posedge clk_in) warm_reg && !idle);

endmodule : flash_host_ctrl

// [flash_dev_model.sv]
`timescale 1ns/1ps
// ==========================================================
// behavioural device: bottom-boot map, small sparse array
module flash_dev_model #(
  parameter logic [7:0] CMD_PROG   = 8'h40,
  parameter logic [7:0] CMD_ERASE  = 8'h20,
  parameter logic [7:0] CMD_CONF   = 8'hd0,
  parameter logic [7:0] CMD_ARRAY  = 8'hff,
  parameter int         BOOT_WORDS = 8192
) (
  // host side
  input  wire flash_host_pkg::flash_pins_type pins_in,
  input  wire logic [15:0]                    dq_host_in,
  // supply above lockout level
  input  wire logic                           vpp_ok_in,
  // data returned
  output logic [15:0]                         dq_dev_out
);
  logic [15:0] mem [int];
  logic [7:0]  pend_reg;
  logic        stat_mode_reg;
  logic        fail_reg;
  logic        ready_reg;
  logic [15:0] rd_word;
  logic [15:0] arr_word;
  int          wa;
  wire         rp = pins_in.reset_powerdown_pin;
  // byte reads pick a lane by the top data pin; byte program not
  // modelled, so byte-mode writes land as word writes
  wire         byte_mode = !pins_in.byte_wide_n;
  wire         lane      = dq_host_in[15];
  assign wa = int'(pins_in.addr);
  wire locked = (wa < BOOT_WORDS) && !pins_in.boot_protect_n &&
                !pins_in.rp_high_voltage;
  // word addresses: boot, two parameter, 96 KB main, then 128 KB mains
  function automatic int blk_base(input int a);
    if (a < 8192) return 0;
    if (a < 16384) return (a < 12288) ? 8192 : 12288;
    if (a < 65536) return 16384;
    return (a / 65536) * 65536;
  endfunction : blk_base
  function automatic logic [15:0] arr_at(input int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction : arr_at
  // ==========================================================
  // command capture and write engine
  always @(posedge pins_in.wr_strobe_n or negedge rp) begin
    if (!rp) begin
      pend_reg      <= 8'h00;
      stat_mode_reg <= 1'b0;
      fail_reg      <= 1'b0;
      ready_reg     <= 1'b1;
    end else if (!pins_in.chip_sel_n) begin
      pend_reg      <= dq_host_in[7:0];
      stat_mode_reg <= (dq_host_in[7:0] != CMD_ARRAY);
      if (pend_reg == CMD_PROG || (pend_reg == CMD_ERASE &&
          dq_host_in[7:0] == CMD_CONF)) begin
        pend_reg      <= 8'h00;
        stat_mode_reg <= 1'b1;
        ready_reg     <= 1'b0;
        ready_reg     <= #200 1'b1;
        if (!vpp_ok_in || locked) fail_reg <= 1'b1;
        else if (pend_reg == CMD_PROG)
          mem[wa] = arr_at(wa) & dq_host_in;
        else
          foreach (mem[k])
            if (blk_base(k) == blk_base(wa)) mem[k] = 16'hffff;
      end
    end
  end
  // released bus shows the inverse, never a stale copy
  always @* begin
    arr_word = arr_at(wa);
    if (byte_mode)
      arr_word = lane ? {8'h00, arr_word[15:8]}
                      : {8'h00, arr_word[7:0]};
    rd_word = stat_mode_reg ?
      {8'h00, ready_reg, 2'b00, fail_reg, 4'h0} : arr_word;
    dq_dev_out = (rp && !pins_in.chip_sel_n && !pins_in.out_en_n) ?
      rd_word : ~rd_word;
  end
endmodule : flash_dev_model

// [test_flash_host_ctrl.sv]
`timescale 1ns/1ps
module test_flash_host_ctrl;
  localparam logic [15:0] PROG = 16'h0040;
  localparam logic [15:0] ERAS = 16'h0020;
  localparam logic [15:0] CONF = 16'h00d0;
  localparam logic [15:0] STAT = 16'h0070;
  logic clk_in, resetn_in, clk_en_in, warm_reset_in, byte_mode_in;
  logic boot_unlock_in, hv_unlock_in, req_valid_in, vpp_ok;
  flash_host_pkg::host_req_type   req_in;
  flash_host_pkg::flash_pins_type pins_out;
  logic        req_ready_out, rsp_valid_out, write_ok_out;
  logic [15:0] rsp_data_out, dq_out, dq_oe_out, dev_q;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // per pin: byte mode has the host on dq15 while the device answers low
  wire [15:0]  dq_bus = (dq_out & dq_oe_out) | (dev_q & ~dq_oe_out);
  flash_host_ctrl flash_host_ctrl_i (.clk_in(clk_in),
    .resetn_in(resetn_in), .clk_en_in(clk_en_in),
    .warm_reset_in(warm_reset_in), .byte_mode_in(byte_mode_in),
    .boot_unlock_in(boot_unlock_in), .hv_unlock_in(hv_unlock_in),
    .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .write_ok_out(write_ok_out),
    .pins_out(pins_out), .dq_in(dq_bus), .dq_out(dq_out),
    .dq_oe_out(dq_oe_out));
  flash_dev_model #(.CMD_CONF(CONF[7:0])) flash_dev_model_i (
    .pins_in(pins_out), .dq_host_in(dq_bus), .vpp_ok_in(vpp_ok),
    .dq_dev_out(dev_q));
  // ==========================================================
  // clock and hang guard
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic req(input logic w, input logic [19:0] a,
                     input logic [15:0] d);
    int n;
    @(negedge clk_in);
    req_in.kind = w ? flash_host_pkg::OP_WRITE : flash_host_pkg::OP_READ;
    req_in.addr = a;
    req_in.data = d;
    req_valid_in = 1'b1;
    // ready is stable between edges, so test it off the edge
    for (n = 0; req_ready_out !== 1'b1 && n < 400; n++) @(negedge clk_in);
    if (n == 400) mismatches++;
    @(negedge clk_in);
    req_valid_in = 1'b0;
  endtask : req
  task automatic rd(input logic [19:0] a, input logic [15:0] exp);
    int n;
    req(1'b0, a, 16'h0000);
    for (n = 0; rsp_valid_out !== 1'b1 && n < 100; n++) @(negedge clk_in);
    if (n == 100) mismatches++;
    chk(rsp_data_out, exp);
  endtask : rd
  task automatic warm();
    @(negedge clk_in);
    warm_reset_in = 1'b1;
    repeat (8) @(negedge clk_in);
    chk({15'h0, pins_out.reset_powerdown_pin}, 16'h0000);
    chk({15'h0, write_ok_out}, 16'h0000);
    warm_reset_in = 1'b0;
  endtask : warm
  // two-write sequence, status read, then warm reset back to array
  task automatic op2(input logic [19:0] a, input logic [15:0] c,
                     input logic [15:0] d, input logic [15:0] st);
    req(1'b1, a, c);
    req(1'b1, a, d);
    req(1'b1, a, STAT);
    rd(a, st);
    warm();
  endtask : op2
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // main sequence
  initial begin
    resetn_in = 1'b0;
    clk_en_in = 1'b1;
    warm_reset_in = 1'b0;
    byte_mode_in = 1'b0;
    boot_unlock_in = 1'b0;
    hv_unlock_in = 1'b0;
    req_valid_in = 1'b0;
    req_in = '0;
    vpp_ok = 1'b1;
    repeat (3) @(negedge clk_in);
    resetn_in = 1'b1;
    rd(20'h20000, 16'hffff);
    chk({15'h0, write_ok_out}, 16'h0001);
    op2(20'h20000, PROG, 16'h1234, 16'h0080);
    rd(20'h20000, 16'h1234);
    rd(20'h20002, 16'hffff);
    byte_mode_in = 1'b1;
    warm();
    chk({15'h0, pins_out.byte_wide_n}, 16'h0000);
    rd(20'h20001, 16'h0012);
    rd(20'h20000, 16'h0034);
    byte_mode_in = 1'b0;
    warm();
    chk({15'h0, pins_out.byte_wide_n}, 16'h0001);
    op2(20'h00020, PROG, 16'h5555, 16'h0090);
    rd(20'h00020, 16'hffff);
    req(1'b1, 20'h00020, STAT);
    rd(20'h00020, 16'h0080);
    hv_unlock_in = 1'b1;
    op2(20'h00020, PROG, 16'h5555, 16'h0080);
    hv_unlock_in = 1'b0;
    rd(20'h00020, 16'h5555);
    boot_unlock_in = 1'b1;
    op2(20'h00022, PROG, 16'ha5a5, 16'h0080);
    rd(20'h00022, 16'ha5a5);
    vpp_ok = 1'b0;
    op2(20'h20004, PROG, 16'h0f0f, 16'h0090);
    vpp_ok = 1'b1;
    rd(20'h20004, 16'hffff);
    op2(20'h20000, ERAS, CONF, 16'h0080);
    rd(20'h20000, 16'hffff);
    rd(20'h00020, 16'h5555);
    tally_and_finish();
  end
endmodule : test_flash_host_ctrl
